/* File: pidan_pkg.sv */
/*
 * pidan_pkg: shared constants of the identifier and auto-negotiation
 * register set: management register addresses, field positions, reset
 * values, management frame codes and fixed identification values.
 * Assumes a clause-22 style serial management frame with 5-bit addresses.
 */
package pidan_pkg;

	// management register addresses
	localparam logic [4:0] REG_ID_HIGH_ADDR  = 5'h02;
	localparam logic [4:0] REG_ID_LOW_ADDR   = 5'h03;
	localparam logic [4:0] REG_ADVERT_ADDR   = 5'h04;
	localparam logic [4:0] REG_PARTNER_ADDR  = 5'h05;
	localparam logic [4:0] REG_EXPAND_ADDR   = 5'h06;

	// identification values; all three are arbitrary neutral values
	localparam logic [23:0] ORG_ID_VALUE     = 24'h5A_A5_3C;
	localparam logic [5:0]  MODEL_CODE_VALUE = 6'h2A;
	localparam logic [3:0]  REV_CODE_VALUE   = 4'h3;

	// advertisement field positions
	localparam int ADV_NEXT_PAGE_BIT   = 15;
	localparam int ADV_REMOTE_FAULT_BIT = 13;
	localparam int ADV_ASYM_PAUSE_BIT  = 11;
	localparam int ADV_SYM_PAUSE_BIT   = 10;
	localparam int ADV_TECH_LSB        = 5;
	localparam int ADV_TECH_MSB        = 8;
	localparam logic [4:0] SELECTOR_IEEE = 5'h01;

	// partner ability field positions
	localparam int LP_NEXT_PAGE_BIT    = 15;

	// expansion register field positions
	localparam int EXP_PDF_BIT         = 4;
	localparam int EXP_LP_NP_BIT       = 3;
	localparam int EXP_LOCAL_NP_BIT    = 2;
	localparam int EXP_PRX_BIT         = 1;
	localparam int EXP_LP_AN_BIT       = 0;

	// status ability bits 14..11 (100 full, 100 half, 10 full, 10 half)
	localparam logic [3:0] STATUS_ABILITY = 4'hF;

	// reset values of the writable advertisement bits
	localparam logic       ADV_RF_RESET    = 1'b0;
	localparam logic       ADV_ASYM_RESET  = 1'b0;
	localparam logic       ADV_SYM_RESET   = 1'b0;
	localparam logic [3:0] ADV_TECH_RESET  = STATUS_ABILITY;

	// management frame fields
	localparam logic [5:0] PREAMBLE_MIN = 6'h20;
	localparam logic [1:0] OP_READ      = 2'h2;
	localparam logic [1:0] OP_WRITE     = 2'h1;
	localparam logic [3:0] ADDR_BITS_LAST = 4'h4;
	localparam logic [3:0] DATA_BITS_LAST = 4'hF;

	// frame receiver states
	typedef enum logic [6:0] {
		ST_PRE   = 7'h01,
		ST_START = 7'h02,
		ST_OP    = 7'h04,
		ST_PHYAD = 7'h08,
		ST_REGAD = 7'h10,
		ST_TA    = 7'h20,
		ST_DATA  = 7'h40
	} pidan_state_e;

endpackage

/* File: pidan_sync.sv */
/*
 * pidan_sync: two-flop synchroniser for a bundle of pin levels.
 * Assumes the bits are independent levels; no word coherence is kept.
 */
module pidan_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule // pidan_sync

/* File: pidan_cor_flag.sv */
/*
 * pidan_cor_flag: sticky event flag cleared by a management read.
 * Assumes set and clear are single-cycle pulses in the core clock domain.
 */
module pidan_cor_flag (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);

	logic flag_nxt;

	// set beats clear so an event in the read cycle waits for the next read
	assign flag_nxt = set_i | (flag_o & ~clr_i);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
		end else begin
			flag_o <= flag_nxt;
		end
	end

endmodule // pidan_cor_flag

/* File: pidan_regs.sv */
/*
 * pidan_regs: identifier and auto-negotiation register set behind the
 * serial management pins, with the frame receiver that reaches it.
 * Assumes the auto-negotiation engine runs on core_clk_i and gives
 * one-cycle pulses; mdc, mdio and the address strap come from pins.
 */
// Operation
// R1: identifier high register is read-only, holding organization id bits 23:8.
// R2: identifier low holds id bits 5:0, model code, revision code, read-only.
// R3: advertisement bit 15 reads zero; next page not supported.
// R4: advertisement remote fault bit is writable, resets zero, sent in code word.
// R5: advertisement asymmetric pause bit is writable, resets zero.
// R6: symmetric pause bit resets zero; treated as writable.
// R7: advertisement bits 12 and 9 read zero.
// R8: advertisement bits 8:5 reset one, settable only when matching ability is one.
// R9: advertisement selector field reads fixed 00001.
// R10: advertisement writes reach the code word only at negotiation restart.
// R11: management may rewrite technology field; defaults come from ability bits.
// R12: partner bit 15 shows partner next page request, resets zero.
// R13: partner bit 14 shows partner acknowledge of consistent bursts.
// R14: partner bit 13 shows partner remote fault, resets zero.
// R15: partner bits 12:5 hold partner technology bits, reset zero.
// R16: partner bits 4:0 hold partner selector, reset zero.
// R17: expansion bit 4 latches parallel detection fault, cleared by read.
// R18: expansion bit 3 shows partner next page ability.
// R19: expansion bit 2 always reads zero.
// R20: expansion bit 1 latches new partner word stored, cleared by read.
// R21: expansion bit 0 shows partner negotiation ability; bits 15:5 read zero.
// R22: status ability bits 14:11 read one and gate advertisement writes.
// R23: completion flag marks advertisement, partner and expansion contents valid.
// R24: latched bits clear only by a management read.
// R25: read returns latched value then clears; same-cycle event stays set.
module pidan_regs
	import pidan_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe_n_o,
	input  wire logic [4:0]  phy_addr_i,
	input  wire logic        an_restart_i,
	output logic      [15:0] adv_codeword_o,
	input  wire logic        lp_word_valid_i,
	input  wire logic [15:0] lp_word_i,
	input  wire logic        parallel_detect_fault_i,
	input  wire logic        partner_autoneg_able_i,
	input  wire logic        autoneg_done_i,
	output logic             autoneg_done_flag_o
);

	// compose the advertisement word from its writable fields
	function automatic logic [15:0] adv_word(input logic rf, input logic asym,
			input logic sym, input logic [3:0] tech);
		adv_word = {1'b0, 1'b0, rf, 1'b0, asym, sym, 1'b0, tech, SELECTOR_IEEE}; // R3 R7 R9
	endfunction

	// pins pass two flops before the frame logic sees them
	logic [6:0] pin_sync;
	logic       mdc_s;
	logic       mdio_s;
	logic [4:0] phy_addr_s;

	pidan_sync #(
		.WIDTH (7)
	) u_pin_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    ({mdc_i, mdio_i, phy_addr_i}),
		.sync_o     (pin_sync)
	);

	assign mdc_s      = pin_sync[6];
	assign mdio_s     = pin_sync[5];
	assign phy_addr_s = pin_sync[4:0];

	// frame state
	pidan_state_e state_r;
	pidan_state_e state_nxt;
	logic         mdc_q_r;
	logic [5:0]   pre_cnt_r;
	logic [3:0]   bit_cnt_r;
	logic [15:0]  shift_in_r;
	logic [1:0]   op_r;
	logic [4:0]   phyad_r;
	logic [4:0]   regad_r;
	logic [15:0]  shift_out_r;
	logic         drive_r;
	logic         out_bit_r;

	// advertisement and partner storage
	logic         adv_rf_r;
	logic         adv_asym_r;
	logic         adv_sym_r;
	logic [3:0]   adv_tech_r;
	logic [15:0]  lp_r;
	logic         pdf_flag;
	logic         prx_flag;

	// decode
	logic         mdc_rise;
	logic         regad_done;
	logic         for_us;
	logic [4:0]   regad_full;
	logic         read_take;
	logic         write_last;
	logic [15:0]  write_word;
	logic         adv_write;
	logic [15:0]  adv_read;
	logic [15:0]  exp_read;
	logic [15:0]  rd_mux;

	assign mdc_rise   = mdc_s & ~mdc_q_r;
	assign regad_full = {regad_r[3:0], mdio_s};
	assign regad_done = mdc_rise && (state_r == ST_REGAD) && (bit_cnt_r == ADDR_BITS_LAST);
	assign for_us     = (phyad_r == phy_addr_s);
	// registers are sampled, and latched bits cleared, once the address is known
	assign read_take  = regad_done && for_us && (op_r == OP_READ); // R24
	assign write_last = mdc_rise && (state_r == ST_DATA) && (bit_cnt_r == DATA_BITS_LAST)
		&& for_us && (op_r == OP_WRITE);
	assign write_word = {shift_in_r[14:0], mdio_s};
	assign adv_write  = write_last && (regad_r == REG_ADVERT_ADDR);

	assign adv_read = adv_word(adv_rf_r, adv_asym_r, adv_sym_r, adv_tech_r);

	// expansion word; local next page and reserved bits stay zero
	assign exp_read = {11'h000, pdf_flag,            // R17 R21
		lp_r[LP_NEXT_PAGE_BIT],                      // R18
		1'b0,                                        // R19
		prx_flag,                                    // R20
		partner_autoneg_able_i};                     // R21

	// read data select; unmapped addresses read zero
	assign rd_mux =
		(regad_full == REG_ID_HIGH_ADDR) ? ORG_ID_VALUE[23:8] :            // R1
		(regad_full == REG_ID_LOW_ADDR)  ?
			{ORG_ID_VALUE[5:0], MODEL_CODE_VALUE, REV_CODE_VALUE} :      // R2
		(regad_full == REG_ADVERT_ADDR)  ? adv_read :
		(regad_full == REG_PARTNER_ADDR) ? lp_r :                          // R12 R15
		(regad_full == REG_EXPAND_ADDR)  ? exp_read : 16'h0000;

	// frame receiver next state
	always_comb begin
		state_nxt = state_r;
		if (mdc_rise) begin
			unique case (state_r)
				ST_PRE: begin
					if (!mdio_s && pre_cnt_r == PREAMBLE_MIN) begin
						state_nxt = ST_START;
					end
				end
				ST_START: begin
					state_nxt = mdio_s ? ST_OP : ST_PRE;
				end
				ST_OP: begin
					if (bit_cnt_r[0]) begin
						state_nxt = ST_PHYAD;
					end
				end
				ST_PHYAD: begin
					if (bit_cnt_r == ADDR_BITS_LAST) begin
						state_nxt = ST_REGAD;
					end
				end
				ST_REGAD: begin
					if (bit_cnt_r == ADDR_BITS_LAST) begin
						state_nxt = ST_TA;
					end
				end
				ST_TA: begin
					if (bit_cnt_r[0]) begin
						state_nxt = ST_DATA;
					end
				end
				ST_DATA: begin
					if (bit_cnt_r == DATA_BITS_LAST) begin
						state_nxt = ST_PRE;
					end
				end
				default: begin
					state_nxt = ST_PRE;
				end
			endcase
		end
	end

	// state, edge history and bit counting
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_r   <= ST_PRE;
			mdc_q_r   <= 1'b0;
			bit_cnt_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			mdc_q_r <= mdc_s;
			if (mdc_rise) begin
				bit_cnt_r <= (state_nxt != state_r) ? 4'h0 : bit_cnt_r + 4'h1;
			end
		end
	end

	// preamble counter saturates; any zero outside a start restarts it,
	// and it clears inside a frame so every frame needs a fresh preamble
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pre_cnt_r <= 6'h00;
		end else if (state_r != ST_PRE) begin
			pre_cnt_r <= 6'h00;
		end else if (mdc_rise) begin
			if (mdio_s) begin
				pre_cnt_r <= (pre_cnt_r == PREAMBLE_MIN) ? pre_cnt_r : pre_cnt_r + 6'h01;
			end else begin
				pre_cnt_r <= 6'h00;
			end
		end
	end

	// header and write data shift in msb first
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			op_r       <= 2'h0;
			phyad_r    <= 5'h00;
			regad_r    <= 5'h00;
			shift_in_r <= 16'h0000;
		end else if (mdc_rise) begin
			if (state_r == ST_OP) begin
				op_r <= {op_r[0], mdio_s};
			end
			if (state_r == ST_PHYAD) begin
				phyad_r <= {phyad_r[3:0], mdio_s};
			end
			if (state_r == ST_REGAD) begin
				regad_r <= regad_full;
			end
			if (state_r == ST_DATA) begin
				shift_in_r <= write_word;
			end
		end
	end

	// read drive: turnaround zero on the second ta bit, then data msb first;
	// released on the edge where the host samples the last data bit
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			shift_out_r <= 16'h0000;
			drive_r     <= 1'b0;
			out_bit_r   <= 1'b1;
		end else if (read_take) begin
			shift_out_r <= rd_mux; // R25
		end else if (mdc_rise && for_us && op_r == OP_READ) begin
			if (state_r == ST_TA && !bit_cnt_r[0]) begin
				drive_r   <= 1'b1;
				out_bit_r <= 1'b0;
			end else if (state_r == ST_TA || (state_r == ST_DATA && bit_cnt_r != DATA_BITS_LAST)) begin
				out_bit_r   <= shift_out_r[15];
				shift_out_r <= {shift_out_r[14:0], 1'b0};
			end else if (state_r == ST_DATA) begin
				drive_r   <= 1'b0;
				out_bit_r <= 1'b1;
			end
		end
	end

	assign mdio_o      = out_bit_r;
	assign mdio_oe_n_o = ~drive_r;

	// advertisement storage; ability bits gate setting the technology bits
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			adv_rf_r   <= ADV_RF_RESET;                                   // R4
			adv_asym_r <= ADV_ASYM_RESET;                                 // R5
			adv_sym_r  <= ADV_SYM_RESET;                                  // R6
			adv_tech_r <= ADV_TECH_RESET;                                 // R8 R11 R22
		end else if (adv_write) begin
			adv_rf_r   <= write_word[ADV_REMOTE_FAULT_BIT];               // R4
			adv_asym_r <= write_word[ADV_ASYM_PAUSE_BIT];                 // R5
			adv_sym_r  <= write_word[ADV_SYM_PAUSE_BIT];                  // R6
			adv_tech_r <= write_word[ADV_TECH_MSB:ADV_TECH_LSB] & STATUS_ABILITY; // R8 R11 R22
		end
	end

	// the code word in use only follows the register at a restart,
	// so a half-finished edit never leaks onto the line
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			adv_codeword_o <= adv_word(ADV_RF_RESET, ADV_ASYM_RESET, ADV_SYM_RESET,
				ADV_TECH_RESET);
		end else if (an_restart_i) begin
			adv_codeword_o <= adv_read; // R10 R4
		end
	end

	// partner word is stored whole as the engine delivers it
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			lp_r <= 16'h0000; // R12 R14 R15 R16
		end else if (lp_word_valid_i) begin
			lp_r <= lp_word_i; // R12 R13 R14 R15 R16
		end
	end

	// latched expansion events
	pidan_cor_flag u_pdf_flag (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.set_i      (parallel_detect_fault_i),
		.clr_i      (read_take && regad_full == REG_EXPAND_ADDR), // R17 R24 R25
		.flag_o     (pdf_flag)
	);

	pidan_cor_flag u_prx_flag (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.set_i      (lp_word_valid_i),
		.clr_i      (read_take && regad_full == REG_EXPAND_ADDR), // R20 R24 R25
		.flag_o     (prx_flag)
	);

	// completion flag tells the status register the contents are valid
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			autoneg_done_flag_o <= 1'b0;
		end else begin
			autoneg_done_flag_o <= autoneg_done_i; // R23
		end
	end

endmodule // pidan_regs

/* File: pidan_checker.sv */
/* pidan_checker: port assertions of pidan_regs.
   assumes one core clock and a synchronous active-high reset. */
module pidan_checker
	import pidan_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        mdio_o,
	input  wire logic        mdio_oe_n_o,
	input  wire logic        an_restart_i,
	input  wire logic [15:0] adv_codeword_o,
	input  wire logic        autoneg_done_i,
	input  wire logic        autoneg_done_flag_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// a read drives 17 mdc periods of 8 cycles; margin covers sync lag
	localparam int DRV_MAX = 150;
	int drv_cnt_r;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// length of the current drive burst on the data pin
	always_ff @(posedge core_clk_i)
		drv_cnt_r <= (rst_i || mdio_oe_n_o) ? 0 : drv_cnt_r + 1;
	property p_cw_hold;
		$changed(adv_codeword_o) && !$past(rst_i) |-> $past(an_restart_i);
	endproperty
	a_cw_hold: assert property (p_cw_hold) else $error("code word moved without restart");
	property p_cw_zero;
		(adv_codeword_o & 16'hD200) == 16'h0000;
	endproperty
	a_cw_zero: assert property (p_cw_zero) else $error("fixed zero bit set in code word");
	property p_cw_sel;
		adv_codeword_o[4:0] == SELECTOR_IEEE;
	endproperty
	a_cw_sel: assert property (p_cw_sel) else $error("selector not 00001");
	property p_cw_tech;
		(adv_codeword_o[8:5] & ~STATUS_ABILITY) == 4'h0;
	endproperty
	a_cw_tech: assert property (p_cw_tech) else $error("unable technology advertised");
	property p_cw_reset;
		$fell(rst_i) |-> adv_codeword_o == 16'h01E1;
	endproperty
	a_cw_reset: assert property (p_cw_reset) else $error("code word reset value wrong");
	property p_done;
		$changed(autoneg_done_i) |=> autoneg_done_flag_o == $past(autoneg_done_i);
	endproperty
	a_done: assert property (p_done) else $error("completion flag did not follow");
	property p_ta_zero;
		$fell(mdio_oe_n_o) |-> !mdio_o;
	endproperty
	a_ta_zero: assert property (p_ta_zero) else $error("turnaround not driven low");
	property p_drv_len;
		drv_cnt_r <= DRV_MAX;
	endproperty
	a_drv_len: assert property (p_drv_len) else $error("data pin driven too long");
endmodule // pidan_checker

bind pidan_regs pidan_checker i_pidan_checker (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o),
	.an_restart_i(an_restart_i), .adv_codeword_o(adv_codeword_o),
	.autoneg_done_i(autoneg_done_i), .autoneg_done_flag_o(autoneg_done_flag_o));

/* File: pidan_mgmt_model.sv */
/* pidan_mgmt_model: station management controller sending frames.
   assumes the bench resolves the shared data line with a pull-up. */
module pidan_mgmt_model
	import pidan_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic mdio_line_i,
	output logic      mdc_o,
	output logic      mdio_o,
	output logic      mdio_en_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// each mdc phase lasts this many core cycles, above the 3-cycle floor
	localparam int HALF = 4;
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_en_o = 1'b0;
	end
	// one frame; data changes at the fall, read bits sampled at the rise
	task automatic frame(input logic [1:0] st, input logic [1:0] op, input logic [4:0] phy,
			input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hFFFF_FFFF, st, op, phy, ra, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			@(posedge core_clk_i);
			mdc_o <= 1'b0;
			mdio_en_o <= (op == OP_WRITE) || (i >= 18);
			mdio_o <= bits[i];
			repeat (HALF) @(posedge core_clk_i);
			mdc_o <= 1'b1;
			if (i < 16) rd[i] = mdio_line_i;
			repeat (HALF - 1) @(posedge core_clk_i);
		end
		// clock stands low and the line is released between frames
		@(posedge core_clk_i);
		mdc_o <= 1'b0;
		mdio_en_o <= 1'b0;
	endtask
endmodule // pidan_mgmt_model

/* File: pidan_regs_tb.sv */
/* pidan_regs_tb: self-checking bench of pidan_regs.
   assumes pidan_mgmt_model stands in for the management controller. */
module pidan_regs_tb
	import pidan_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk_i = 1'b0, rst_i = 1'b1, done = 1'b0, lp_able = 1'b0;
	logic [2:0]  stb = 3'h0;
	logic [4:0]  phy = 5'h00;
	logic [15:0] lp_word = 16'h0000, rd, w, adv, cw;
	logic        mdc, h_dat, h_en, d_dat, d_oe_n, line, done_flg;
	integer      seed;
	int          mismatches = 0, check_count = 0;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
	always #5 core_clk_i = ~core_clk_i;
	// shared data line: device, then host, else the pull-up
	assign line = !d_oe_n ? d_dat : (h_en ? h_dat : 1'b1);
	pidan_regs i_pidan_regs (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(line),
		.mdio_o(d_dat), .mdio_oe_n_o(d_oe_n), .phy_addr_i(phy), .an_restart_i(stb[0]),
		.adv_codeword_o(cw), .lp_word_valid_i(stb[1]), .lp_word_i(lp_word),
		.parallel_detect_fault_i(stb[2]), .partner_autoneg_able_i(lp_able),
		.autoneg_done_i(done), .autoneg_done_flag_o(done_flg));
	pidan_mgmt_model i_pidan_mgmt_model (
		.core_clk_i(core_clk_i), .mdio_line_i(line), .mdc_o(mdc), .mdio_o(h_dat),
		.mdio_en_o(h_en));
	function automatic logic [15:0] adv_exp(input logic [15:0] v);
		adv_exp = {2'b00, v[13], 1'b0, v[11:10], 1'b0, v[8:5] & STATUS_ABILITY, SELECTOR_IEEE};
	endfunction
	function automatic logic [15:0] exp6(input logic f, np, page_received_flag, able);
		exp6 = {11'h000, f, np, 1'b0, page_received_flag, able};
	endfunction
	task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
		i_pidan_mgmt_model.frame(2'b01, OP_READ, phy, a, 16'h0000, d);
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] x;
		i_pidan_mgmt_model.frame(2'b01, OP_WRITE, phy, a, d, x);
	endtask
	// one-cycle engine strobe; a spare edge keeps drivers apart
	task automatic pulse(input int k);
		@(posedge core_clk_i);
		stb[k] <= 1'b1;
		@(posedge core_clk_i);
		stb[k] <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic complete_run();
		if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk_i);
		mismatches++;
		complete_run();
	end
	// main sequence
	initial begin
		seed = 32'h0000_E0A3;
		phy = 5'($random(seed));
		adv = 16'h01E1;
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		rd_reg(REG_ID_HIGH_ADDR, rd);
		`CHK(rd, ORG_ID_VALUE[23:8])
		rd_reg(REG_ID_LOW_ADDR, rd);
		`CHK(rd, {ORG_ID_VALUE[5:0], MODEL_CODE_VALUE, REV_CODE_VALUE})
		rd_reg(REG_ADVERT_ADDR, rd);
		`CHK(rd, adv)
		// corners, then random words; code word moves only at restart
		for (int i = 0; i < 6; i++) begin
			w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
			wr_reg(REG_ADVERT_ADDR, w);
			rd_reg(REG_ADVERT_ADDR, rd);
			`CHK(rd, adv_exp(w))
			`CHK(cw, adv)
			pulse(0);
			adv = adv_exp(w);
			`CHK(cw, adv)
		end
		// refused writes, unmapped place, foreign address, bad start bits
		wr_reg(REG_ID_HIGH_ADDR, 16'h0000);
		rd_reg(REG_ID_HIGH_ADDR, rd);
		`CHK(rd, ORG_ID_VALUE[23:8])
		wr_reg(REG_PARTNER_ADDR, 16'hFFFF);
		rd_reg(REG_PARTNER_ADDR, rd);
		`CHK(rd, 16'h0000)
		rd_reg(5'h1F, rd);
		`CHK(rd, 16'h0000)
		i_pidan_mgmt_model.frame(2'b01, OP_WRITE, phy ^ 5'h01, REG_ADVERT_ADDR, 16'h0000, rd);
		i_pidan_mgmt_model.frame(2'b01, OP_READ, phy ^ 5'h01, REG_ADVERT_ADDR, 16'h0000, rd);
		`CHK(rd, 16'hFFFF)
		i_pidan_mgmt_model.frame(2'b00, OP_WRITE, phy, REG_ADVERT_ADDR, 16'h0000, rd);
		rd_reg(REG_ADVERT_ADDR, rd);
		`CHK(rd, adv)
		// partner words with and without next page, flags cleared by reading
		for (int k = 0; k < 2; k++) begin
			lp_able <= ~lp_able;
			lp_word <= k ? (16'($random(seed)) & 16'h7FFF) : (16'($random(seed)) | 16'h8000);
			pulse(1);
			rd_reg(REG_PARTNER_ADDR, rd);
			`CHK(rd, lp_word)
			rd_reg(REG_EXPAND_ADDR, rd);
			`CHK(rd, exp6(1'b0, lp_word[15], 1'b1, lp_able))
			rd_reg(REG_EXPAND_ADDR, rd);
			`CHK(rd, exp6(1'b0, lp_word[15], 1'b0, lp_able))
		end
		pulse(2);
		rd_reg(REG_EXPAND_ADDR, rd);
		`CHK(rd[4], 1'b1)
		// fault landing in the very cycle the read clears must survive it
		fork
			rd_reg(REG_EXPAND_ADDR, rd);
			begin
				repeat (366) @(posedge core_clk_i);
				pulse(2);
			end
		join
		`CHK(rd[4], 1'b0)
		rd_reg(REG_EXPAND_ADDR, rd);
		`CHK(rd[4], 1'b1)
		done <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		`CHK(done_flg, 1'b1)
		done <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		`CHK(done_flg, 1'b0)
		complete_run();
	end
endmodule // pidan_regs_tb
